// file: verilog/drfc_checker.sv
`timescale 1ns/10ps
`include "drfc_cfg.svh"
module drfc_checker (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Completion record write
  output logic             crec_write,
  output logic      [63:0] crec_addr,
  output logic      [7:0]  crec_status,
  output logic      [31:0] crec_bytes_done,
  output logic      [23:0] crec_invalid_flags,
  // Check verdict
  output logic             desc_exec,
  output logic             desc_reject
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic drfc_pkg::drfc_bmask_t brange(input int lo, input int hi);
    drfc_pkg::drfc_bmask_t m;
    m = '0;
    for (int i = 0; i < 64; i++) begin
      if (i >= lo && i <= hi) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic drfc_pkg::drfc_bmask_t op_rsvd(input drfc_pkg::drfc_op_t op);
    drfc_pkg::drfc_bmask_t m;
    m = '0;
    case (op)
      `DRFC_OP_NOOP:     m = brange(16, 35) | brange(38, 63);
      `DRFC_OP_DRAIN:    m = brange(32, 35) | brange(38, 63);
      `DRFC_OP_MOVE:     m = brange(38, 63);
      `DRFC_OP_FILL:     m = brange(38, 63);
      `DRFC_OP_CMP:      m = brange(38, 39) | brange(41, 63);
      `DRFC_OP_CMPPAT:   m = brange(38, 39) | brange(41, 63);
      `DRFC_OP_CRDELTA:  m = brange(38, 39) | brange(52, 55) | brange(57, 63);
      `DRFC_OP_APDELTA:  m = brange(38, 39) | brange(44, 63);
      `DRFC_OP_DUALCAST: m = brange(38, 39) | brange(48, 63);
      `DRFC_OP_CRCGEN:   m = brange(24, 31) | brange(38, 39) | brange(44, 63);
      `DRFC_OP_COPYCRC:  m = brange(38, 39) | brange(44, 63);
      `DRFC_OP_DIFCHK:   m = brange(24, 31) | brange(38, 39) | brange(41, 41) | brange(43, 47) | brange(56, 63);
      `DRFC_OP_DIFSTRP:  m = brange(24, 31) | brange(38, 39) | brange(41, 41) | brange(43, 47) | brange(56, 63);
      `DRFC_OP_DIFINS:   m = brange(38, 39) | brange(40, 40) | brange(43, 55);
      `DRFC_OP_DIFUPD:   m = brange(38, 39) | brange(43, 47);
      `DRFC_OP_CFLUSH:   m = brange(16, 23) | brange(38, 63);
      `DRFC_OP_BATCH:    m = brange(24, 31) | brange(38, 63);
      `DRFC_OP_IDCOPY:   m = brange(38, 59);
      `DRFC_OP_IDFILL:   m = brange(38, 39) | brange(48, 61);
      `DRFC_OP_IDCMP:    m = brange(38, 39) | brange(41, 59);
      `DRFC_OP_IDCMPPAT: m = brange(38, 39) | brange(41, 59) | brange(62, 63);
      `DRFC_OP_UPDWIN:   m = brange(32, 35) | brange(38, 60);
      `DRFC_OP_TFETCH:   m = brange(24, 31) | brange(38, 47) | brange(52, 63);
      // Unknown codes are not rejected anywhere; check their reserved bytes as a no-op
      default:           m = brange(16, 35) | brange(38, 63);
    endcase
    return m;
  endfunction

  function automatic drfc_pkg::drfc_flags_t fbit(input int pos);
    drfc_pkg::drfc_flags_t f;
    f = '0;
    f[pos] = 1'b1;
    return f;
  endfunction

  // Restricted flags each operation may use
  function automatic drfc_pkg::drfc_flags_t op_allow(input drfc_pkg::drfc_op_t op);
    drfc_pkg::drfc_flags_t wr_set;
    drfc_pkg::drfc_flags_t cmp_set;
    drfc_pkg::drfc_flags_t a;
    wr_set  = fbit(`DRFC_F_BOF) | fbit(`DRFC_F_CC) | fbit(`DRFC_F_SO) | fbit(`DRFC_F_DRB)
            | fbit(`DRFC_F_TC1) | fbit(`DRFC_F_TC2) | fbit(`DRFC_F_FENCE);
    cmp_set = fbit(`DRFC_F_BOF) | fbit(`DRFC_F_CHK) | fbit(`DRFC_F_TC1) | fbit(`DRFC_F_TC2)
            | fbit(`DRFC_F_FENCE);
    a       = '0;
    case (op)
      `DRFC_OP_NOOP, `DRFC_OP_BATCH, `DRFC_OP_UPDWIN: a = fbit(`DRFC_F_FENCE);
      `DRFC_OP_DRAIN:    a = fbit(`DRFC_F_TC1) | fbit(`DRFC_F_TC2) | fbit(`DRFC_F_FENCE);
      `DRFC_OP_CMP, `DRFC_OP_CMPPAT, `DRFC_OP_CRCGEN, `DRFC_OP_DIFCHK,
      `DRFC_OP_IDCMP, `DRFC_OP_IDCMPPAT: a = cmp_set;
      `DRFC_OP_DUALCAST, `DRFC_OP_COPYCRC: a = wr_set | fbit(`DRFC_F_TC3);
      `DRFC_OP_CFLUSH:   a = fbit(`DRFC_F_BOF) | fbit(`DRFC_F_SO) | fbit(`DRFC_F_DRB) | fbit(`DRFC_F_FENCE);
      `DRFC_OP_TFETCH:   a = fbit(`DRFC_F_BOF) | fbit(`DRFC_F_FENCE);
      default:           a = wr_set;
    endcase
    return a;
  endfunction

  // Operation-specific flag bits each operation defines
  function automatic drfc_pkg::drfc_flags_t op_spec(input drfc_pkg::drfc_op_t op);
    drfc_pkg::drfc_flags_t s;
    s = '0;
    case (op)
      `DRFC_OP_DRAIN, `DRFC_OP_IDCOPY, `DRFC_OP_IDCMP: s = fbit(`DRFC_F_OPS0) | fbit(`DRFC_F_OPS1);
      `DRFC_OP_IDFILL:   s = fbit(`DRFC_F_OPS1);
      `DRFC_OP_IDCMPPAT: s = fbit(`DRFC_F_OPS0);
      `DRFC_OP_UPDWIN:   s = fbit(`DRFC_F_OPS0);
      default:           s = '0;
    endcase
    return s;
  endfunction

  function automatic logic op_writes(input drfc_pkg::drfc_op_t op);
    return op == `DRFC_OP_MOVE || op == `DRFC_OP_FILL || op == `DRFC_OP_CRDELTA
        || op == `DRFC_OP_APDELTA || op == `DRFC_OP_DUALCAST || op == `DRFC_OP_COPYCRC
        || op == `DRFC_OP_DIFINS || op == `DRFC_OP_DIFSTRP || op == `DRFC_OP_DIFUPD
        || op == `DRFC_OP_IDCOPY || op == `DRFC_OP_IDFILL;
  endfunction

  function automatic logic op_interdom(input drfc_pkg::drfc_op_t op);
    return op == `DRFC_OP_IDCOPY || op == `DRFC_OP_IDFILL || op == `DRFC_OP_IDCMP
        || op == `DRFC_OP_IDCMPPAT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  drfc_pkg::drfc_state_t     state_reg;
  drfc_pkg::drfc_op_t        op_reg;
  drfc_pkg::drfc_flags_t     flags_reg;
  logic                      priv_reg;
  logic [63:0]               craddr_reg;
  logic [`DRFC_CFG_WIDTH-1:0] cfg_reg;
  logic                      in_batch_reg;
  logic [4:0]                scan_idx_reg;
  logic                      data_vld_reg;
  logic [3:0]                data_idx_reg;
  logic                      field_fail_reg;
  logic                      done_reg;
  logic                      fail_reg;
  logic [7:0]                last_status_reg;
  drfc_pkg::drfc_flags_t     last_inv_reg;
  logic                      swerr_vld_reg;
  logic [7:0]                swerr_status_reg;
  drfc_pkg::drfc_flags_t     swerr_flags_reg;
  logic [31:0]               ram_rdata;
  logic                      ram_we;
  logic                      start;
  logic                      buf_hit;
  drfc_pkg::drfc_bmask_t     rsvd_mask;
  drfc_pkg::drfc_flags_t     inv_flags;
  logic                      word_fail;
  logic                      any_fail;
  logic [7:0]                fail_status;

  assign buf_hit = reg_addr[7:6] == `DRFC_BUF_BASE_HI;
  // Descriptor buffer is frozen during a check so the scan sees one descriptor
  assign ram_we  = reg_wr && buf_hit && state_reg == drfc_pkg::DRFC_IDLE;
  assign start   = reg_wr && reg_addr == `DRFC_OFF_CTRL && reg_wdata[`DRFC_CTRL_SUBMIT]
                && state_reg == drfc_pkg::DRFC_IDLE;

  drfc_desc_ram u_ram (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (ram_we),
    .wr_addr (reg_addr[5:2]),
    .wr_data (reg_wdata),
    .rd_addr (scan_idx_reg[3:0]),
    .rd_data (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reserved byte mask: operation table plus conditional fields
  always_comb begin
    rsvd_mask = op_rsvd(op_reg);
    if (!flags_reg[`DRFC_F_CRAV]) begin
      rsvd_mask = rsvd_mask | brange(8, 15);
    end
    if (!flags_reg[`DRFC_F_RCI]) begin
      rsvd_mask = rsvd_mask | brange(36, 37);
    end
    if (op_interdom(op_reg) && !flags_reg[`DRFC_F_OPS0]) begin
      rsvd_mask = rsvd_mask | brange(60, 61);
    end
    if (op_interdom(op_reg) && !flags_reg[`DRFC_F_OPS1]) begin
      rsvd_mask = rsvd_mask | brange(62, 63);
    end
    if (op_reg == `DRFC_OP_UPDWIN && !flags_reg[`DRFC_F_OPS0]) begin
      rsvd_mask = rsvd_mask | brange(16, 31);
    end
    if (op_reg == `DRFC_OP_UPDWIN && (!flags_reg[`DRFC_F_OPS0] || !cfg_reg[`DRFC_CFG_CAPOFS])) begin
      rsvd_mask = rsvd_mask | brange(61, 61);
    end
  end

  // Any reserved byte of the word now on the read port that is not zero
  always_comb begin
    word_fail = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (rsvd_mask[{data_idx_reg, 2'(b)}] && ram_rdata[8*b +: 8] != 8'h00) begin
        word_fail = 1'b1;
      end
    end
  end

  // Flags set where they may not be
  always_comb begin
    inv_flags = flags_reg & `DRFC_ALWAYS_RSVD;
    inv_flags = inv_flags | (flags_reg & `DRFC_OPSPEC_MASK & ~op_spec(op_reg));
    inv_flags = inv_flags | (flags_reg & `DRFC_RESTRICT_MASK & ~op_allow(op_reg));
    if (!cfg_reg[`DRFC_CFG_UIE] && cfg_reg[`DRFC_CFG_WQPASID] && !priv_reg) begin
      inv_flags[`DRFC_F_RCI] = flags_reg[`DRFC_F_RCI];
    end
    if (!in_batch_reg) begin
      inv_flags[`DRFC_F_FENCE] = flags_reg[`DRFC_F_FENCE];
    end
    if (!cfg_reg[`DRFC_CFG_WQBOF]) begin
      inv_flags[`DRFC_F_BOF] = flags_reg[`DRFC_F_BOF];
    end
    if (!cfg_reg[`DRFC_CFG_CAPDRB]) begin
      inv_flags[`DRFC_F_DRB] = flags_reg[`DRFC_F_DRB];
    end
    if (op_reg == `DRFC_OP_DRAIN && !flags_reg[`DRFC_F_OPS0]) begin
      inv_flags[`DRFC_F_TC1] = flags_reg[`DRFC_F_TC1];
    end
    if (op_reg == `DRFC_OP_DRAIN && !flags_reg[`DRFC_F_OPS1]) begin
      inv_flags[`DRFC_F_TC2] = flags_reg[`DRFC_F_TC2];
    end
    if (!flags_reg[`DRFC_F_CRAV]) begin
      inv_flags[`DRFC_F_RCR]  = flags_reg[`DRFC_F_RCR];
      inv_flags[`DRFC_F_CRTC] = flags_reg[`DRFC_F_CRTC];
    end
    if (op_writes(op_reg) && !cfg_reg[`DRFC_CFG_CAPCC]) begin
      inv_flags[`DRFC_F_CC] = flags_reg[`DRFC_F_CC];
    end
    if (op_reg == `DRFC_OP_DRAIN && !cfg_reg[`DRFC_CFG_CAPDRNRB]) begin
      inv_flags[`DRFC_F_OPS0] = flags_reg[`DRFC_F_OPS0];
      inv_flags[`DRFC_F_OPS1] = flags_reg[`DRFC_F_OPS1];
    end
  end

  assign any_fail    = inv_flags != '0 || field_fail_reg;
  assign fail_status = inv_flags != '0 ? `DRFC_ST_FLAGERR : `DRFC_ST_FIELDERR;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one word per cycle, report one cycle after the last word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg    <= drfc_pkg::DRFC_IDLE;
      scan_idx_reg <= 5'h00;
      data_vld_reg <= 1'b0;
      data_idx_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        drfc_pkg::DRFC_IDLE: begin
          data_vld_reg <= 1'b0;
          scan_idx_reg <= 5'h00;
          if (start) begin
            state_reg <= drfc_pkg::DRFC_SCAN;
          end
        end
        drfc_pkg::DRFC_SCAN: begin
          data_vld_reg <= !scan_idx_reg[4];
          data_idx_reg <= scan_idx_reg[3:0];
          if (!scan_idx_reg[4]) begin
            scan_idx_reg <= scan_idx_reg + 5'h01;
          end
          if (data_vld_reg && data_idx_reg == `DRFC_LAST_WORD) begin
            state_reg    <= drfc_pkg::DRFC_REPORT;
            data_vld_reg <= 1'b0;
          end
        end
        drfc_pkg::DRFC_REPORT: begin
          state_reg <= drfc_pkg::DRFC_IDLE;
        end
      endcase
    end
  end

  // Descriptor header capture and field verdict
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      priv_reg       <= 1'b0;
      op_reg         <= 8'h00;
      flags_reg      <= 24'h00_0000;
      craddr_reg     <= 64'h0000_0000_0000_0000;
      field_fail_reg <= 1'b0;
    end else if (start) begin
      field_fail_reg <= 1'b0;
    end else if (data_vld_reg) begin
      unique case (data_idx_reg)
        4'h0: priv_reg <= ram_rdata[`DRFC_PRIV_BIT];
        4'h1: begin
          flags_reg <= ram_rdata[23:0];
          op_reg    <= ram_rdata[31:24];
        end
        4'h2: craddr_reg[31:0] <= ram_rdata;
        4'h3: craddr_reg[63:32] <= ram_rdata;
        default: ;
      endcase
      // Words 0 and 1 hold no reserved bytes, and op_reg is not yet valid for them
      if (data_idx_reg >= 4'h2 && word_fail) begin
        field_fail_reg <= 1'b1;
      end
    end
  end

  // Verdict outputs and completion record
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crec_write         <= 1'b0;
      crec_addr          <= 64'h0000_0000_0000_0000;
      crec_status        <= 8'h00;
      crec_bytes_done    <= 32'h0000_0000;
      crec_invalid_flags <= 24'h00_0000;
      desc_exec          <= 1'b0;
      desc_reject        <= 1'b0;
    end else begin
      crec_write  <= 1'b0;
      desc_exec   <= 1'b0;
      desc_reject <= 1'b0;
      if (state_reg == drfc_pkg::DRFC_REPORT) begin
        desc_exec   <= !any_fail;
        desc_reject <= any_fail;
        if (any_fail && flags_reg[`DRFC_F_CRAV]) begin
          crec_write         <= 1'b1;
          crec_addr          <= craddr_reg;
          crec_status        <= fail_status;
          crec_bytes_done    <= 32'h0000_0000;
          crec_invalid_flags <= inv_flags;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_reg      <= `DRFC_CFG_RESET;
      in_batch_reg <= 1'b0;
    end else if (reg_wr && state_reg == drfc_pkg::DRFC_IDLE) begin
      // Configuration is held steady while a check is running
      if (reg_addr == `DRFC_OFF_CONFIG) begin
        cfg_reg <= reg_wdata[`DRFC_CFG_WIDTH-1:0];
      end
      if (reg_addr == `DRFC_OFF_CTRL) begin
        in_batch_reg <= reg_wdata[`DRFC_CTRL_INBATCH];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_reg        <= 1'b0;
      fail_reg        <= 1'b0;
      last_status_reg <= 8'h00;
      last_inv_reg    <= 24'h00_0000;
    end else if (start) begin
      done_reg <= 1'b0;
    end else if (state_reg == drfc_pkg::DRFC_REPORT) begin
      done_reg        <= 1'b1;
      fail_reg        <= any_fail;
      last_status_reg <= any_fail ? fail_status : `DRFC_ST_SUCCESS;
      last_inv_reg    <= inv_flags;
    end
  end

  // Error log for failures with no completion record; a new error beats a clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swerr_vld_reg    <= 1'b0;
      swerr_status_reg <= 8'h00;
      swerr_flags_reg  <= 24'h00_0000;
    end else if (state_reg == drfc_pkg::DRFC_REPORT && any_fail && !flags_reg[`DRFC_F_CRAV]) begin
      swerr_vld_reg    <= 1'b1;
      swerr_status_reg <= fail_status;
      swerr_flags_reg  <= inv_flags;
    end else if (reg_wr && reg_addr == `DRFC_OFF_SWERR && reg_wdata[0]) begin
      swerr_vld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DRFC_OFF_CTRL:     reg_rdata <= {30'h0000_0000, in_batch_reg, 1'b0};
        `DRFC_OFF_CONFIG:   reg_rdata <= {25'h000_0000, cfg_reg};
        `DRFC_OFF_STATUS:   reg_rdata <= {16'h0000, last_status_reg, 5'h00, fail_reg, done_reg,
                                          state_reg != drfc_pkg::DRFC_IDLE};
        `DRFC_OFF_INVFLAGS: reg_rdata <= {8'h00, last_inv_reg};
        `DRFC_OFF_SWERR:    reg_rdata <= {16'h0000, swerr_status_reg, 7'h00, swerr_vld_reg};
        `DRFC_OFF_SWERRFLG: reg_rdata <= {8'h00, swerr_flags_reg};
        `DRFC_OFF_CRADDRLO: reg_rdata <= craddr_reg[31:0];
        `DRFC_OFF_CRADDRHI: reg_rdata <= craddr_reg[63:32];
        // Unmapped offsets and the write-only descriptor buffer read as zero
        default:            reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// file: verilog/drfc_cfg.svh
`ifndef DRFC_CFG_SVH
`define DRFC_CFG_SVH
// What this block does
// - Flag bits 5, 6 and 15 are reserved for every operation.
// - Flag bits 23:16 must be zero unless the operation defines them.
// - Restricted flags are limited by each operation's allowed list; other flags pass that check.
// - No-op, move, fill and batch descriptors keep their listed byte ranges zero.
// - Create-delta-record keeps bytes 38-39, 52-55 and 57-63 zero.
// - CRC generation and copy-with-CRC keep their listed byte ranges zero.
// - DIF check and DIF strip keep bytes 24-31, 38-39, 41, 43-47, 56-63 zero.
// - DIF insert and DIF update keep their listed byte ranges zero.
// - Inter-domain compare-pattern keeps bytes 38-39, 41-59 and 62-63 zero.
// - Translation fetch keeps listed bytes zero, allows only fault-block and fence.
// - Completion interrupt request is reserved with user interrupts off, PASID on, unprivileged.
// - Completion interrupt handle is reserved when no completion interrupt is requested.
// - Fence is reserved for descriptors submitted directly, outside a batch.
// - Fault-blocking flag is reserved when the queue disables fault blocking.
// - Destination readback flag is reserved without destination readback capability.
// - Drain traffic-class selectors 1 and 2 need their readback-address valid bits.
// - Without a valid completion record address, its address, request and class are reserved.
// - Cache control is reserved on memory-writing operations without cache control capability.
// - Drain readback valid bits are reserved without drain readback capability.
// - Inter-domain table handles are reserved when their alternate-ID flag is clear.
// - Window mode is reserved when window enable or offset-mode capability is zero.
// - Window base and window size are reserved when window enable is zero.
// - A failed check with a completion record writes failure, zero bytes, bad flags.
// - A failed check without completion record is logged in the software error register.

// Register offsets
`define DRFC_OFF_CTRL      8'h00
`define DRFC_OFF_CONFIG    8'h04
`define DRFC_OFF_STATUS    8'h08
`define DRFC_OFF_INVFLAGS  8'h0c
`define DRFC_OFF_SWERR     8'h10
`define DRFC_OFF_SWERRFLG  8'h14
`define DRFC_OFF_CRADDRLO  8'h18
`define DRFC_OFF_CRADDRHI  8'h1c
`define DRFC_BUF_BASE_HI   2'h1

// Control and configuration bits
`define DRFC_CTRL_SUBMIT   0
`define DRFC_CTRL_INBATCH  1
`define DRFC_CFG_UIE       0
`define DRFC_CFG_WQPASID   1
`define DRFC_CFG_WQBOF     2
`define DRFC_CFG_CAPDRB    3
`define DRFC_CFG_CAPCC     4
`define DRFC_CFG_CAPDRNRB  5
`define DRFC_CFG_CAPOFS    6
`define DRFC_CFG_WIDTH     7
`define DRFC_CFG_RESET     7'h00

// Descriptor flag positions
`define DRFC_F_FENCE       0
`define DRFC_F_BOF         1
`define DRFC_F_CRAV        2
`define DRFC_F_RCR         3
`define DRFC_F_RCI         4
`define DRFC_F_CHK         7
`define DRFC_F_CC          8
`define DRFC_F_TC1         9
`define DRFC_F_TC2         10
`define DRFC_F_TC3         11
`define DRFC_F_CRTC        12
`define DRFC_F_SO          13
`define DRFC_F_DRB         14
`define DRFC_F_OPS0        16
`define DRFC_F_OPS1        17
`define DRFC_ALWAYS_RSVD   24'h00_8060
`define DRFC_OPSPEC_MASK   24'hff_0000
`define DRFC_RESTRICT_MASK 24'h00_6f83
`define DRFC_PRIV_BIT      31

// Operation codes
`define DRFC_OP_NOOP       8'h00
`define DRFC_OP_BATCH      8'h01
`define DRFC_OP_DRAIN      8'h02
`define DRFC_OP_MOVE       8'h03
`define DRFC_OP_FILL       8'h04
`define DRFC_OP_CMP        8'h05
`define DRFC_OP_CMPPAT     8'h06
`define DRFC_OP_CRDELTA    8'h07
`define DRFC_OP_APDELTA    8'h08
`define DRFC_OP_DUALCAST   8'h09
`define DRFC_OP_TFETCH     8'h0a
`define DRFC_OP_CRCGEN     8'h10
`define DRFC_OP_COPYCRC    8'h11
`define DRFC_OP_DIFCHK     8'h12
`define DRFC_OP_DIFINS     8'h13
`define DRFC_OP_DIFSTRP    8'h14
`define DRFC_OP_DIFUPD     8'h15
`define DRFC_OP_CFLUSH     8'h20
`define DRFC_OP_IDCOPY     8'h23
`define DRFC_OP_IDFILL     8'h24
`define DRFC_OP_IDCMP      8'h25
`define DRFC_OP_IDCMPPAT   8'h26
`define DRFC_OP_UPDWIN     8'h21

// Status codes
`define DRFC_ST_SUCCESS    8'h01
`define DRFC_ST_FLAGERR    8'h10
`define DRFC_ST_FIELDERR   8'h11

// Descriptor geometry
`define DRFC_DESC_WORDS    16
`define DRFC_LAST_WORD     4'hf
`endif

// file: verilog/drfc_pkg.sv
package drfc_pkg;
  typedef enum logic [2:0] {
    DRFC_IDLE   = 3'b001,
    DRFC_SCAN   = 3'b010,
    DRFC_REPORT = 3'b100
  } drfc_state_t;
  typedef logic [7:0]  drfc_op_t;
  typedef logic [23:0] drfc_flags_t;
  typedef logic [63:0] drfc_bmask_t;
endpackage

// file: verilog/drfc_desc_ram.sv
`timescale 1ns/10ps
module drfc_desc_ram (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // Read port
  input  wire logic [3:0]  rd_addr,
  output logic      [31:0] rd_data
);
  logic [31:0] mem_reg [0:15];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule

// file: verif/drfc_checker_sva.sv
`timescale 1ns/10ps
module drfc_checker_sva (
  // Clock, reset and register port
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Verdict and completion record
  input wire logic        desc_exec,
  input wire logic        desc_reject,
  input wire logic        crec_write,
  input wire logic [63:0] crec_addr,
  input wire logic [7:0]  crec_status,
  input wire logic [31:0] crec_bytes_done,
  input wire logic [23:0] crec_invalid_flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_submit;
    reg_wr && reg_addr == 8'h00 && reg_wdata[0];
  endsequence
  sequence s_verdict;
    desc_exec || desc_reject;
  endsequence
  chk_verdict_delay: assert property (s_verdict |-> $past(reg_wr && reg_addr == 8'h00 && reg_wdata[0], 19))
    else $error("Verdict without a submit nineteen cycles before");
  chk_submit_answer: assert property (s_submit |-> ##19 s_verdict)
    else $error("Submit got no verdict after nineteen cycles");
  chk_one_verdict: assert property (s_verdict |-> !(desc_exec && desc_reject) ##1 !(desc_exec || desc_reject))
    else $error("Verdict not a single one-cycle pulse");
  chk_record_reject: assert property (crec_write |-> desc_reject && crec_bytes_done == 32'h0000_0000)
    else $error("Record without reject or with bytes done");
  chk_record_status: assert property (crec_write |-> crec_status inside {8'h10, 8'h11})
    else $error("Record status not a failure code");
  chk_flag_status: assert property (crec_write && crec_invalid_flags != 24'h00_0000 |-> crec_status == 8'h10)
    else $error("Invalid flags without flag status");
  chk_field_flags: assert property (crec_write && crec_status == 8'h11 |-> crec_invalid_flags == 24'h00_0000)
    else $error("Field status with invalid flags");
  chk_record_hold: assert property (!crec_write |-> $stable(crec_addr) && $stable(crec_status))
    else $error("Record data moved without a write");
endmodule
bind drfc_checker drfc_checker_sva u_drfc_checker_sva (.*);

// file: verif/drfc_host.sv
`timescale 1ns/10ps
module drfc_host (
  // Clock and read data
  input  wire logic        clock,
  input  wire logic [31:0] reg_rdata,
  // Register requests
  output logic      [7:0]  reg_addr = 8'h00,
  output logic      [31:0] reg_wdata = 32'h0000_0000,
  output logic             reg_wr = 1'b0,
  output logic             reg_rd = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  // One byte at bt and one flag at fb are the only deliberate faults
  task automatic send(input int op, fb, cfg, bt, input logic [7:0] ctl, input logic [63:0] cra);
    logic [31:0] w [16];
    foreach (w[i]) w[i] = 32'h0000_0000;
    w[1][31:24] = op[7:0];
    if (fb < 24) w[1][fb] = 1'b1;
    w[2] = cra[31:0];
    w[3] = cra[63:32];
    // Fault byte goes in after the address words so they cannot hide it
    if (bt < 64) w[bt / 4][8 * (bt % 4) +: 8] = 8'h5a;
    w[1][2] = (cra != 64'h0);
    wr(8'h04, cfg[31:0]);
    foreach (w[i]) wr(8'h40 + 8'(4 * i), w[i]);
    wr(8'h00, {24'h00_0000, ctl | 8'h01});
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  typedef struct { int op, fb, cfg, bt, x; } drfc_row_t;
  logic clock = 1'b0, rst = 1'b1, reg_wr, reg_rd, desc_exec, desc_reject, crec_write;
  logic [7:0]  reg_addr, crec_status;
  logic [31:0] reg_wdata, reg_rdata, crec_bytes_done, d;
  logic [63:0] crec_addr;
  logic [23:0] crec_invalid_flags;
  int errors = 0, n_compared = 0, cyc = 0;
  // Rows: opcode, flag bit (99 none), config, nonzero byte (99 none), reject expected
  drfc_row_t rows [$] = '{'{0,99,0,99,0}, '{0,5,0,99,1}, '{3,15,0,99,1}, '{3,16,0,99,1}, '{0,99,0,16,1},
    '{3,99,0,16,0}, '{1,99,0,24,1}, '{7,99,0,56,0}, '{7,99,0,57,1}, '{16,99,0,24,1}, '{17,99,0,24,0},
    '{18,99,0,41,1}, '{18,99,0,42,0}, '{19,99,0,40,1}, '{21,99,0,40,0}, '{38,99,0,62,1}, '{10,13,0,99,1},
    '{10,1,4,99,0}, '{0,4,2,99,1}, '{0,4,3,99,0}, '{3,99,0,36,1}, '{3,0,0,99,1}, '{3,1,0,99,1}, '{3,1,4,99,0},
    '{3,14,0,99,1}, '{3,14,8,99,0}, '{2,9,0,99,1}, '{2,16,0,99,1}, '{2,16,32,99,0}, '{3,3,0,99,1},
    '{3,99,0,8,1}, '{3,8,0,99,1}, '{3,8,16,99,0}, '{35,99,0,60,1}, '{33,99,0,61,1}, '{33,99,0,16,1},
    '{33,16,0,61,1}, '{33,16,64,61,0}};
  always #12.5 clock = ~clock;
  drfc_checker u_drfc_checker (.*);
  drfc_host u_drfc_host (.*);
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic run(input drfc_row_t r, input logic [7:0] ctl, input logic [63:0] cra);
    u_drfc_host.send(r.op, r.fb, r.cfg, r.bt, ctl, cra);
    for (int i = 0; i < 30 && desc_exec !== 1'b1 && desc_reject !== 1'b1; i++) @(negedge clock);
    chk((desc_exec ^ desc_reject) === 1'b1, "no single verdict");
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // About 60 cycles a descriptor; the ceiling leaves wide margin
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      run(rows[i], 8'h00, 64'h0);
      chk(desc_reject === rows[i].x[0], "row verdict");
      $display("Row %0d done", i);
    end
    run('{3, 0, 0, 99, 0}, 8'h02, 64'h0);
    chk(desc_exec === 1'b1, "fence refused inside batch");
    $display("Batch fence test done");
    run('{3, 5, 0, 99, 1}, 8'h00, 64'h0123_4567_89ab_cde0);
    chk(crec_write === 1'b1 && crec_bytes_done === 32'h0 && crec_status === 8'h10 && crec_invalid_flags[5] === 1'b1
      && crec_addr === 64'h0123_4567_89ab_cde0, "completion record");
    $display("Completion record test done");
    u_drfc_host.wr(8'h10, 32'h0000_0001);
    run('{0, 6, 0, 99, 1}, 8'h00, 64'h0);
    u_drfc_host.rd(8'h10, d);
    chk(d[0] === 1'b1 && d[15:8] === 8'h10, "error register");
    $display("Error register test done");
    // Reset lands in the middle of a running check
    u_drfc_host.send(3, 99, 0, 99, 8'h00, 64'h0);
    repeat (5) @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    u_drfc_host.rd(8'h08, d);
    chk(d === 32'h0 && crec_status === 8'h00, "state after reset");
    u_drfc_host.rd(8'h10, d);
    chk(d === 32'h0, "error log after reset");
    $display("Reset test done");
    report_and_stop();
  end
endmodule
